// ==== common/interp_cmd_defines.svh ====
// Purpose: Constants of the phase read-out and command block
// Assumes: Register indices are chosen locally
// Notes:   Definitions only
`ifndef INTERP_CMD_DEFINES_SVH
`define INTERP_CMD_DEFINES_SVH

// ==========================================================
// Register indices
`define PHASE_DELTA_REG_INDEX   2'h0
`define PHASE_DEV_REG_INDEX     2'h1
`define COMMAND_REG_INDEX       2'h2

// ==========================================================
// Command bit positions
`define CMD_COUNTER_PRESET_BIT  0
`define CMD_CONTROLLER_RST_BIT  1
`define CMD_CLEAR_REF_BIT       2
`define CMD_CHIP_REINIT_BIT     3
`define CMD_STORE_CONFIG_BIT    4
`define CMD_LATCH_HWA_BIT       5

// ==========================================================
// Phase ranges per rate family
`define PHASE_MOD_256           9'h100
`define PHASE_MOD_200           9'h0C8
`define PHASE_MOD_160           9'h0A0
`define DELTA_LIMIT_256         10'h05F
`define DELTA_LIMIT_200         10'h04A
`define DELTA_LIMIT_160         10'h03C

// ==========================================================
// Reset values
`define PHASE_RESET             8'h00
`define DELTA_RESET             16'h0000
`define HWA_RESET               4'h0
`define RDATA_RESET             32'h0000_0000

`endif

// ==== common/interp_cmd_pkg.sv ====
// Purpose: Types of the phase read-out and command block
// Assumes: Nothing
// Notes:   Types only
package interp_cmd_pkg;

	// Interpolation rate family
	typedef enum logic [1:0]
	{
		RATE_FAMILY_256,
		RATE_FAMILY_200,
		RATE_FAMILY_160
	} rate_family_t;

	// Reference point mode
	typedef enum logic [1:0]
	{
		REF_MODE_PLAIN,
		REF_MODE_ADJUST_ZERO,
		REF_MODE_DISTANCE_CODED
	} ref_mode_t;

endpackage

// ==== verilog/interpolator_phase_and_command.sv ====
// Purpose: Phase read-out words and command trigger register
// Assumes: Raw phase below the family modulus; sync inputs
// Notes:   Register port is a simple strobe port
//
// Operation
// - Upper half of the first word holds the signed phase change.
// - The phase change is held within -95..94, -74..73 or -60..59.
// - Lower half holds the unsigned phase angle from zero upward.
// - The phase angle peaks at 255, 199 or 159 by rate family.
// - The phase zero offset shifts the reported angle.
// - Second word holds the angle low and controller deviation high.
// - Command bit 5 latches the four hardware address pins.
// - Serial sensor mode latches the address while init_done is high.
// - Command bit 4 stores configuration and corrections to EEPROM.
// - Command bit 3 resets and reconfigures the chip.
// - Command bit 2 clears the reference flag and may restart search.
// - Command bit 1 centres all gain and offset corrections.
// - Command bit 0 presets counters, clears errors and reference.
`timescale 1ns/10ps

`include "interp_cmd_defines.svh"

module interpolator_phase_and_command
	import interp_cmd_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	// Register port
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [1:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	output logic      [31:0]  reg_rdata,
	// Interpolation core
	input  wire logic         sample_strobe,
	input  wire logic [7:0]   phase_raw,
	input  wire rate_family_t rate_family,
	input  wire logic [7:0]   phase_zero_offset,
	input  wire logic [15:0]  controller_deviation,
	input  wire ref_mode_t    ref_mode,
	// Address pins and initialisation
	input  wire logic [3:0]   hardware_address_pins,
	input  wire logic         sensor_serial_mode,
	input  wire logic         init_done,
	output logic      [3:0]   hardware_address,
	output logic      [3:0]   serial_number_low,
	// Command actions
	output logic              latch_hw_address_cmd,
	output logic              store_config_cmd,
	output logic              chip_reinit_cmd,
	output logic              clear_reference_cmd,
	output logic              controller_reset_cmd,
	output logic              counter_preset_cmd,
	output logic              clear_errors,
	output logic              restart_reference,
	output logic              clear_reference_found
);

	// ==========================================================
	// Functions
	function automatic logic [8:0] phase_modulus(input rate_family_t f);
		case (f)
			RATE_FAMILY_200: phase_modulus = `PHASE_MOD_200;
			RATE_FAMILY_160: phase_modulus = `PHASE_MOD_160;
			default:         phase_modulus = `PHASE_MOD_256;
		endcase
	endfunction

	function automatic logic [9:0] delta_limit(input rate_family_t f);
		case (f)
			RATE_FAMILY_200: delta_limit = `DELTA_LIMIT_200;
			RATE_FAMILY_160: delta_limit = `DELTA_LIMIT_160;
			default:         delta_limit = `DELTA_LIMIT_256;
		endcase
	endfunction

	// ==========================================================
	// Phase angle and phase change
	logic        [7:0]  phase_angle;
	logic        [15:0] phase_delta;
	logic        [8:0]  modulus;
	logic signed [9:0]  limit_pos;
	logic        [8:0]  shifted_sum;
	logic        [7:0]  next_phase_angle;
	logic signed [9:0]  raw_diff;
	logic signed [9:0]  half_mod;
	logic signed [9:0]  wrapped_diff;
	logic signed [9:0]  clamped_diff;

	assign modulus     = phase_modulus(rate_family);
	assign limit_pos   = $signed(delta_limit(rate_family));
	assign half_mod    = $signed({2'h0, modulus[8:1]});
	assign shifted_sum = {1'b0, phase_raw} + {1'b0, phase_zero_offset};
	assign next_phase_angle = (shifted_sum >= modulus)
		? 8'(shifted_sum - modulus)
		: shifted_sum[7:0];
	assign raw_diff = $signed({2'h0, next_phase_angle})
		- $signed({2'h0, phase_angle});
	assign wrapped_diff = (raw_diff >= half_mod)
		? 10'(raw_diff - $signed({1'b0, modulus}))
		: (raw_diff < -half_mod)
		? 10'(raw_diff + $signed({1'b0, modulus}))
		: raw_diff;
	assign clamped_diff = (wrapped_diff >= limit_pos)
		? 10'(limit_pos - 10'sd1)
		: (wrapped_diff < -limit_pos)
		? 10'(-limit_pos)
		: wrapped_diff;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			phase_angle <= `PHASE_RESET;
			phase_delta <= `DELTA_RESET;
		end
		else if (sample_strobe)
		begin
			phase_angle <= next_phase_angle;
			phase_delta <= {{6{clamped_diff[9]}}, clamped_diff};
		end
	end

	// ==========================================================
	// Read path
	logic [31:0] word_one;
	logic [31:0] word_two;
	logic [31:0] next_rdata;

	assign word_one = {phase_delta, 8'h00, phase_angle};
	assign word_two = {controller_deviation, 8'h00, phase_angle};
	assign next_rdata =
		(reg_addr == `PHASE_DELTA_REG_INDEX) ? word_one :
		(reg_addr == `PHASE_DEV_REG_INDEX)   ? word_two :
		`RDATA_RESET;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			reg_rdata <= `RDATA_RESET;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

	// ==========================================================
	// Command decode
	logic cmd_wr;
	logic restart_mode;
	logic auto_latch;
	logic next_latch;

	assign cmd_wr       = reg_wr && (reg_addr == `COMMAND_REG_INDEX);
	assign restart_mode = (ref_mode == REF_MODE_ADJUST_ZERO)
		|| (ref_mode == REF_MODE_DISTANCE_CODED);
	assign auto_latch   = sensor_serial_mode && init_done;
	assign next_latch   = cmd_wr && reg_wdata[`CMD_LATCH_HWA_BIT];

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			latch_hw_address_cmd <= 1'b0;
			store_config_cmd     <= 1'b0;
			chip_reinit_cmd      <= 1'b0;
			clear_reference_cmd  <= 1'b0;
			controller_reset_cmd <= 1'b0;
			counter_preset_cmd   <= 1'b0;
		end
		else
		begin
			latch_hw_address_cmd <= next_latch;
			store_config_cmd <= cmd_wr
				&& reg_wdata[`CMD_STORE_CONFIG_BIT];
			chip_reinit_cmd <= cmd_wr
				&& reg_wdata[`CMD_CHIP_REINIT_BIT];
			clear_reference_cmd <= cmd_wr
				&& reg_wdata[`CMD_CLEAR_REF_BIT];
			controller_reset_cmd <= cmd_wr
				&& reg_wdata[`CMD_CONTROLLER_RST_BIT];
			counter_preset_cmd <= cmd_wr
				&& reg_wdata[`CMD_COUNTER_PRESET_BIT];
		end
	end

	// Derived actions
	assign clear_errors          = counter_preset_cmd;
	assign clear_reference_found = clear_reference_cmd
		|| counter_preset_cmd;
	assign restart_reference     = restart_mode
		&& (clear_reference_cmd || counter_preset_cmd);

	// ==========================================================
	// Hardware address latch
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			hardware_address <= `HWA_RESET;
		else if (next_latch || auto_latch)
			hardware_address <= hardware_address_pins;
	end

	assign serial_number_low = hardware_address;

	// ==========================================================
	// Assertions
	a_delta_range: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		$past(sample_strobe) && !$past(sys_rst) |->
		($signed(phase_delta) < $signed({6'h00, $past(limit_pos)}))
		&& ($signed(phase_delta) >= -$signed({6'h00, $past(limit_pos)})))
		else $error("phase change out of range");
	a_delta_sign: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		sample_strobe |=> phase_delta[15:7] == {9{phase_delta[15]}})
		else $error("phase change not sign extended");
	a_phase_max: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		sample_strobe |=> {1'b0, phase_angle} < $past(modulus))
		else $error("phase angle above maximum");
	a_phase_offset: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		sample_strobe && (phase_zero_offset == 8'h00) |=>
		phase_angle == $past(phase_raw))
		else $error("zero offset shifted angle");
	a_word_one: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		reg_rd && (reg_addr == `PHASE_DELTA_REG_INDEX) |=>
		reg_rdata == {$past(phase_delta), 8'h00, $past(phase_angle)})
		else $error("first word wrong");
	a_word_two: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		reg_rd && (reg_addr == `PHASE_DEV_REG_INDEX) |=>
		reg_rdata == {$past(controller_deviation), 8'h00,
		$past(phase_angle)})
		else $error("second word wrong");
	a_rdata_hold: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!reg_rd && !sys_rst |=> $stable(reg_rdata))
		else $error("read data changed without read");
	a_hwa_latch: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && reg_wdata[`CMD_LATCH_HWA_BIT] |=>
		latch_hw_address_cmd
		&& (hardware_address == $past(hardware_address_pins)))
		else $error("address not latched");
	a_auto_latch: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		auto_latch |=> serial_number_low == $past(hardware_address_pins))
		else $error("auto latch missed");
	a_store_cmd: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && reg_wdata[`CMD_STORE_CONFIG_BIT] |=> store_config_cmd)
		else $error("store not started");
	a_reinit_cmd: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && reg_wdata[`CMD_CHIP_REINIT_BIT] |=> chip_reinit_cmd)
		else $error("reinit not started");
	a_clear_ref: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && reg_wdata[`CMD_CLEAR_REF_BIT] && restart_mode |=>
		clear_reference_found && restart_reference)
		else $error("reference not cleared");
	a_ctl_reset: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && reg_wdata[`CMD_CONTROLLER_RST_BIT] |=>
		controller_reset_cmd)
		else $error("controller reset missed");
	a_preset_all: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && reg_wdata[`CMD_COUNTER_PRESET_BIT] |=>
		counter_preset_cmd && clear_errors && clear_reference_found)
		else $error("preset incomplete");
	a_preset_restart: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && reg_wdata[`CMD_COUNTER_PRESET_BIT] && restart_mode
		|=> restart_reference)
		else $error("preset did not restart search");
	a_self_clear: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!cmd_wr |=> !store_config_cmd && !chip_reinit_cmd
		&& !counter_preset_cmd && !latch_hw_address_cmd
		&& !clear_reference_cmd && !controller_reset_cmd)
		else $error("command did not clear");
	a_high_bits: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && (reg_wdata[5:0] == 6'h00) |=>
		!store_config_cmd && !chip_reinit_cmd && !counter_preset_cmd
		&& !latch_hw_address_cmd && !clear_reference_cmd
		&& !controller_reset_cmd)
		else $error("upper command bits acted");

	// ==========================================================
	// Cover points
	c_preset: cover property (@(posedge clk_sys) disable iff (sys_rst)
		counter_preset_cmd && restart_reference);
	c_wrap: cover property (@(posedge clk_sys) disable iff (sys_rst)
		sample_strobe && (raw_diff >= half_mod));
	c_latch: cover property (@(posedge clk_sys) disable iff (sys_rst)
		next_latch ##1 latch_hw_address_cmd);
	c_clamp: cover property (@(posedge clk_sys) disable iff (sys_rst)
		sample_strobe && (wrapped_diff < -limit_pos));
	c_high_bits: cover property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && (reg_wdata[7:6] != 2'h0));

endmodule

// ==== tb/host_port_model.sv ====
// Purpose: Host side of the register strobe port
// Assumes: Calls start just after a falling edge
// Notes:   Idle address and data show the inverse of the last value
`timescale 1ns/10ps

module host_port_model
(
	// Clock
	input  wire logic       clk_sys,
	// Register port
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [1:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h3;
		reg_wdata = 8'h00;
	end

	// =========================================================
	// Command write, address and data driven together for one clock
	task automatic wr_cmd(input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = 2'h2;
		reg_wdata = d;
		@(posedge clk_sys);
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = 2'h1;
		reg_wdata = ~d;
	endtask

	// =========================================================
	// Word read
	task automatic rd_word(input logic [1:0] a);
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk_sys);
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// ==== tb/interpolator_phase_and_command_tb_top.sv ====
// Purpose: Self-checking bench of the phase and command block
// Assumes: Inputs change at the falling edge
// Notes:   Host model drives the register port
`timescale 1ns/10ps

module interpolator_phase_and_command_tb_top
	import interp_cmd_pkg::*;
;
	logic         clk_sys, sys_rst, reg_wr, reg_rd, sample_strobe;
	logic [1:0]   reg_addr;
	logic [7:0]   reg_wdata, phase_raw, phase_zero_offset;
	logic [31:0]  reg_rdata;
	logic [15:0]  controller_deviation;
	rate_family_t rate_family;
	ref_mode_t    ref_mode;
	logic [3:0]   pins, hardware_address, serial_number_low;
	logic         sensor_serial_mode, init_done;
	wire  [5:0]   pulses;
	wire  [2:0]   extras;
	int           error_cnt, num_checks, i;

	interpolator_phase_and_command dut_u
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
		.phase_raw(phase_raw), .rate_family(rate_family),
		.phase_zero_offset(phase_zero_offset),
		.controller_deviation(controller_deviation), .ref_mode(ref_mode),
		.hardware_address_pins(pins),
		.sensor_serial_mode(sensor_serial_mode), .init_done(init_done),
		.hardware_address(hardware_address),
		.serial_number_low(serial_number_low),
		.latch_hw_address_cmd(pulses[5]), .store_config_cmd(pulses[4]),
		.chip_reinit_cmd(pulses[3]), .clear_reference_cmd(pulses[2]),
		.controller_reset_cmd(pulses[1]), .counter_preset_cmd(pulses[0]),
		.clear_errors(extras[2]), .clear_reference_found(extras[1]),
		.restart_reference(extras[0])
	);

	host_port_model host_u
	(
		.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata)
	);

	// =========================================================
	// Checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic smp(input logic [7:0] raw);
		phase_raw = raw;
		sample_strobe = 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		sample_strobe = 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, input logic [31:0] exp);
		host_u.rd_word(a);
		chk(reg_rdata, exp);
	endtask

	// =========================================================
	// Clock and watchdog
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (3000) @(posedge clk_sys);
		error_cnt++;
		stop_test();
	end

	// =========================================================
	// Main sequence
	initial
	begin
		error_cnt = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		{sample_strobe, sensor_serial_mode, init_done} = 3'h0;
		{phase_raw, phase_zero_offset} = 16'h0000;
		rate_family = RATE_FAMILY_256;
		ref_mode = REF_MODE_ADJUST_ZERO;
		controller_deviation = 16'h00A0;
		pins = 4'hA;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		chk(32'(hardware_address), 32'h0);
		host_u.wr_cmd(8'h20);
		chk(32'({hardware_address, serial_number_low}), 32'hAA);
		$display("test address latch done");
		@(negedge clk_sys);
		for (i = 0; i < 6; i++)
		begin
			host_u.wr_cmd(8'h01 << i);
			chk(32'({pulses, extras}), 32'({6'h01 << i, i == 0,
				i == 0 || i == 2, i == 0 || i == 2}));
			@(negedge clk_sys);
			chk(32'({pulses, extras}), 32'h0);
		end
		ref_mode = REF_MODE_PLAIN;
		host_u.wr_cmd(8'h05);
		chk(32'({pulses, extras}), 32'h02E);
		@(negedge clk_sys);
		host_u.wr_cmd(8'hC0);
		chk(32'({pulses, extras}), 32'h0);
		@(negedge clk_sys);
		ref_mode = REF_MODE_DISTANCE_CODED;
		host_u.wr_cmd(8'h04);
		chk(32'({pulses, extras}), 32'h023);
		$display("test command bits done");
		smp(8'h0A);
		rd(2'h0, 32'h000A_000A);
		smp(8'hC8);
		rd(2'h0, 32'hFFBE_00C8);
		smp(8'h3C);
		rd(2'h0, 32'h005E_003C);
		phase_zero_offset = 8'h05;
		smp(8'h3C);
		rd(2'h1, 32'h00A0_0041);
		@(negedge clk_sys);
		rd(2'h0, 32'h0005_0041);
		rate_family = RATE_FAMILY_200;
		phase_zero_offset = 8'h00;
		smp(8'hC7);
		rd(2'h0, 32'hFFBE_00C7);
		@(negedge clk_sys);
		rd(2'h2, 32'h0);
		rate_family = RATE_FAMILY_160;
		smp(8'h00);
		rd(2'h0, 32'hFFD9_0000);
		smp(8'h50);
		rd(2'h0, 32'hFFC4_0050);
		$display("test phase words done");
		sys_rst = 1'b1;
		@(negedge clk_sys);
		sys_rst = 1'b0;
		chk(reg_rdata, 32'h0);
		chk(32'(hardware_address), 32'h0);
		rd(2'h0, 32'h0);
		$display("test mid-run reset done");
		pins = 4'h5;
		sensor_serial_mode = 1'b1;
		init_done = 1'b1;
		@(negedge clk_sys);
		init_done = 1'b0;
		@(negedge clk_sys);
		chk(32'({hardware_address, serial_number_low}), 32'h55);
		$display("test serial mode latch done");
		stop_test();
	end
endmodule
